// [shared/rcs_pkg.sv]
/*
  Constants and types for the reset cause and start-up timer block.
  Assumes a 250 MHz core clock and an 8-bit core register file bus.
*/
package rcs_pkg;

  // ----------------------------------------
  // Clock and start-up timer
  // ----------------------------------------
  localparam int RCS_CLK_MHZ = 250;
  localparam int RCS_STARTUP_MS = 18;
  // Nominal start-up period in cycles; 18 ms at 250 MHz
  localparam int RCS_STARTUP_CYCLES = RCS_STARTUP_MS * RCS_CLK_MHZ * 1000;
  localparam int RCS_TIMER_W = 23;

  // ----------------------------------------
  // Register file access
  // ----------------------------------------
  localparam int RCS_ADDR_W = 5;
  localparam logic [4:0] RCS_CORE_STATUS_ADDR = 5'h03;
  localparam logic [7:0] RCS_READ_ZERO = 8'h00;

  // Field positions inside core_status
  localparam int RCS_PAGE_HI_BIT = 7;
  localparam int RCS_PAGE_MID_BIT = 6;
  localparam int RCS_PAGE_LO_BIT = 5;
  localparam int RCS_TIMEOUT_BIT = 4;
  localparam int RCS_POWERDOWN_BIT = 3;

  // Values after reset
  localparam logic [2:0] RCS_PAGE_RESET = 3'h0;
  localparam logic RCS_TIMEOUT_POR = 1'b1;
  localparam logic RCS_POWERDOWN_POR = 1'b1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic page_select_hi;
    logic page_select_mid;
    logic page_select_lo;
    logic timeout_flag;
    logic powerdown_flag;
    logic [2:0] alu_flags;
  } rcs_status_s;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
  } rcs_cause_s;

  typedef enum logic [1:0] {
    RCS_RUN = 2'b00,
    RCS_HALT = 2'b01,
    RCS_HOLD = 2'b10
  } rcs_mode_e;

endpackage : rcs_pkg

// [verilog/rcs_startup_timer.sv]
/*
  Start-up timer: counts while enabled, restarts on request.
  Assumes restart and run are synchronous to clk.
*/
`timescale 1ns/1ps
module rcs_startup_timer #(
  parameter int STARTUP_CYCLES = rcs_pkg::RCS_STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic restart,
  input wire logic run,
  output logic expired
);

  logic [rcs_pkg::RCS_TIMER_W-1:0] count;
  logic [rcs_pkg::RCS_TIMER_W-1:0] next_count;
  wire logic [rcs_pkg::RCS_TIMER_W-1:0] last_count =
    rcs_pkg::RCS_TIMER_W'(STARTUP_CYCLES - 1);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Saturates at the last count so expired stays up until restart
  assign expired = (count == last_count);
  assign next_count = restart ? '0 :
                      (run && !expired) ? count + 1'b1 : count;

  // Cleared at power-up
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      count <= '0;
    else
      count <= next_count;
  end

  chk_timer_restart : assert property (@(posedge clk) disable iff (!resetn)
    restart |=> (count == '0) && !expired)
    else $error("Start-up timer did not restart");

endmodule : rcs_startup_timer

// [verilog/rcs_reset_control.sv]
/*
  Reset control: merges power-on, clear pin and watchdog resets,
  holds the internal reset through a latch and the start-up timer,
  and keeps the reset cause flags inside core_status.
  Assumes resetn is the power-on detector output, and that all other
  inputs are synchronous to clk.
*/
// Contract
// - Five reset sources: power-on, clear pin run/halt, watchdog run/halt.
// - Wake from halt by clear pin or watchdog is a full reset.
// - Time-out and power-down flags sit at core_status bits 4 and 3.
// - Power-on sets both flags; clear pin in normal run keeps them.
// - Clear pin waking halt: time-out flag 1, power-down flag 0.
// - Watchdog in normal run: time-out flag 0, power-down flag 1.
// - Watchdog waking halt: both flags cleared to 0.
// - Undefined-reset bits power up unknown; later resets leave them unchanged.
// - Other bits take reset values on power-on, clear pin, watchdog.
// - Power-up sets the reset latch and clears the start-up timer.
// - Timer counts while pin high; after its period it ends reset.
// - Falling supply never raises an internal reset.
`timescale 1ns/1ps
module rcs_reset_control #(
  parameter int STARTUP_CYCLES = rcs_pkg::RCS_STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ext_clear_pin_n,
  input wire logic wdt_timeout,
  input wire logic sleep_cmd,
  input wire logic [rcs_pkg::RCS_ADDR_W-1:0] reg_addr,
  input wire logic reg_we,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic device_reset,
  output logic halted
);

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  logic reset_latch;
  logic pin_low_q;
  logic timer_expired;
  rcs_pkg::rcs_mode_e mode;
  rcs_pkg::rcs_mode_e next_mode;

  // The pin is a level; its first low cycle marks a clear-pin reset
  wire logic pin_low = !ext_clear_pin_n;
  wire logic clear_entry = pin_low && !pin_low_q;
  wire logic in_halt = (mode == rcs_pkg::RCS_HALT);
  wire logic wdt_event = wdt_timeout && !reset_latch;
  // Either reset source ends halt with a full reset, never a resume
  wire logic reset_event = clear_entry || wdt_event;
  wire logic sleep_ok = sleep_cmd && (mode == rcs_pkg::RCS_RUN);
  // Only the pin or the watchdog can raise the latch after power-up;
  // no supply monitor feeds it, so a falling supply does nothing
  wire logic latch_set = pin_low || wdt_event;
  wire logic latch_clear = timer_expired && ext_clear_pin_n;

  // Previous pin level; reset value high so a pin held low at
  // power-up still records a clear-pin reset once resetn releases
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pin_low_q <= 1'b0;
    else
      pin_low_q <= pin_low;
  end

  // ----------------------------------------
  // Reset latch and start-up timer
  // ----------------------------------------
  // Set wins over clear so a new cause is never lost
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reset_latch <= 1'b1;
    else if (latch_set)
      reset_latch <= 1'b1;
    else if (latch_clear)
      reset_latch <= 1'b0;
  end

  assign device_reset = reset_latch;

  // Restart on low pin or watchdog; count only while the pin is high
  rcs_startup_timer #(
    .STARTUP_CYCLES(STARTUP_CYCLES)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .restart(latch_set),
    .run(reset_latch && ext_clear_pin_n),
    .expired(timer_expired)
  );

  // ----------------------------------------
  // Operating mode
  // ----------------------------------------
  // Any reset drops halt into hold, so execution restarts from the vector
  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      rcs_pkg::RCS_RUN:
        if (sleep_ok)
          next_mode = rcs_pkg::RCS_HALT;
      rcs_pkg::RCS_HALT:
        next_mode = mode;
      rcs_pkg::RCS_HOLD:
        if (latch_clear)
          next_mode = rcs_pkg::RCS_RUN;
      default:
        next_mode = rcs_pkg::RCS_HOLD;
    endcase
    if (latch_set)
      next_mode = rcs_pkg::RCS_HOLD;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mode <= rcs_pkg::RCS_HOLD;
    else
      mode <= next_mode;
  end

  assign halted = in_halt;

  // ----------------------------------------
  // Reset cause flags
  // ----------------------------------------
  rcs_pkg::rcs_cause_s cause;
  rcs_pkg::rcs_cause_s next_cause;

  // Pin wake and watchdog decide the flags; a plain pin reset keeps them
  always_comb
  begin
    next_cause = cause;
    if (clear_entry && in_halt)
    begin
      next_cause.timeout_flag = 1'b1;
      next_cause.powerdown_flag = 1'b0;
    end
    else if (wdt_event && in_halt)
    begin
      next_cause.timeout_flag = 1'b0;
      next_cause.powerdown_flag = 1'b0;
    end
    else if (wdt_event)
    begin
      next_cause.timeout_flag = 1'b0;
      next_cause.powerdown_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cause.timeout_flag <= rcs_pkg::RCS_TIMEOUT_POR;
      cause.powerdown_flag <= rcs_pkg::RCS_POWERDOWN_POR;
    end
    else
      cause <= next_cause;
  end

  // ----------------------------------------
  // core_status register
  // ----------------------------------------
  logic [2:0] page;
  logic [2:0] alu_flags;
  rcs_pkg::rcs_status_s status;

  wire logic status_sel = (reg_addr == rcs_pkg::RCS_CORE_STATUS_ADDR);
  // A write in the cycle of a reset event is dropped, so the alu bits do not move then
  wire logic status_we = reg_we && status_sel && !reset_latch && !latch_set;
  wire logic [2:0] page_wdata = reg_wdata[rcs_pkg::RCS_PAGE_HI_BIT:rcs_pkg::RCS_PAGE_LO_BIT];

  // Page bits take their reset value on every kind of reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      page <= rcs_pkg::RCS_PAGE_RESET;
    else if (latch_set)
      page <= rcs_pkg::RCS_PAGE_RESET;
    else if (status_we)
      page <= page_wdata;
  end

  // No reset at all: unknown at power-up, untouched by later resets
  always_ff @(posedge clk)
  begin
    if (status_we)
      alu_flags <= reg_wdata[2:0];
  end

  // Cause flags are read-only; writes to bits 4:3 are dropped
  assign status.page_select_hi = page[2];
  assign status.page_select_mid = page[1];
  assign status.page_select_lo = page[0];
  assign status.timeout_flag = cause.timeout_flag;
  assign status.powerdown_flag = cause.powerdown_flag;
  assign status.alu_flags = alu_flags;

  // Read data registered; unmapped addresses read zero
  wire logic [7:0] next_rdata = status_sel ? status : rcs_pkg::RCS_READ_ZERO;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= rcs_pkg::RCS_READ_ZERO;
    else
      reg_rdata <= next_rdata;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Set by the first write; bits 2:0 have no defined value before it
  logic alu_written;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      alu_written <= 1'b0;
    else if (status_we)
      alu_written <= 1'b1;
  end

  sequence s_pin_wake;
    clear_entry && in_halt;
  endsequence

  sequence s_wdt_run;
    wdt_event && !in_halt;
  endsequence

  sequence s_wdt_wake;
    wdt_event && in_halt;
  endsequence

  chk_pin_wake_flags : assert property (
    @(posedge clk) disable iff (!resetn)
    s_pin_wake |=> cause.timeout_flag && !cause.powerdown_flag)
    else $error("Clear-pin wake set wrong cause flags");

  chk_wdt_run_flags : assert property (
    @(posedge clk) disable iff (!resetn)
    s_wdt_run |=> !cause.timeout_flag && cause.powerdown_flag)
    else $error("Watchdog reset set wrong cause flags");

  chk_wdt_wake_flags : assert property (
    @(posedge clk) disable iff (!resetn)
    s_wdt_wake |=> !cause.timeout_flag && !cause.powerdown_flag)
    else $error("Watchdog wake set wrong cause flags");

  chk_pin_keeps_flags : assert property (
    @(posedge clk) disable iff (!resetn)
    (clear_entry && !in_halt && !wdt_event) |=> $stable(cause))
    else $error("Clear-pin reset changed cause flags");

  chk_wake_is_reset : assert property (
    @(posedge clk) disable iff (!resetn)
    (s_pin_wake or s_wdt_wake) |=> device_reset && !halted [*2])
    else $error("Wake did not give a full reset");

  chk_pin_holds_reset : assert property (
    @(posedge clk) disable iff (!resetn)
    pin_low [*3] |=> device_reset && (mode == rcs_pkg::RCS_HOLD))
    else $error("Low clear pin did not hold reset");

  chk_release_cause : assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(device_reset) |-> $past(timer_expired) && $past(ext_clear_pin_n))
    else $error("Reset ended before the start-up timer expired");

  chk_no_spurious_set : assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(device_reset) |-> $past(pin_low) || $past(wdt_timeout))
    else $error("Internal reset raised without a cause");

  chk_page_reset : assert property (
    @(posedge clk) disable iff (!resetn)
    reset_event |=> (page == rcs_pkg::RCS_PAGE_RESET) ##1 device_reset)
    else $error("Page bits not reset");

  chk_alu_kept : assert property (
    @(posedge clk) disable iff (!resetn)
    (reset_event && alu_written) |=> $stable(alu_flags))
    else $error("Reset disturbed bits with no reset state");

  chk_hold_till_expiry : assert property (
    @(posedge clk) disable iff (!resetn)
    (device_reset && !timer_expired) |=> device_reset)
    else $error("Reset ended while the start-up timer ran");

  chk_status_read : assert property (
    @(posedge clk) disable iff (!resetn)
    (status_sel && $stable(cause)) |=>
      reg_rdata[rcs_pkg::RCS_TIMEOUT_BIT:rcs_pkg::RCS_POWERDOWN_BIT] == $past(cause))
    else $error("Cause flags not at bits 4:3");

endmodule : rcs_reset_control

// [sim/rcs_supervisor.sv]
/*
  Partner model: the external supervisor that drives the clear pin.
  Assumes the bench drives vdd_ok, go and hold just after rising edges.
*/
`timescale 1ns/1ps
module rcs_supervisor (
  input wire logic clk,
  input wire logic vdd_ok,
  input wire logic go,
  input wire logic [7:0] hold,
  output logic ext_clear_pin_n
);
  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  int cnt = 0;
  initial ext_clear_pin_n = 1'b0;
  // Pin low while supply is poor or a hold runs; pull-up gives high
  always @(posedge clk)
  begin
    if (cnt > 0)
      cnt--;
    else if (go)
      cnt = hold;
    ext_clear_pin_n <= vdd_ok && (cnt == 0);
  end
endmodule : rcs_supervisor

// [sim/rcs_reset_control_tb.sv]
/*
  Self-checking bench for the reset control block with a flag model.
  Assumes the short start-up count and the supervisor partner model.
*/
`timescale 1ns/1ps
module rcs_reset_control_tb;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  localparam int SC = 16;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pin_n;
  logic wdt = 1'b0;
  logic sleep = 1'b0;
  logic [4:0] addr = 5'h03;
  logic we = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic dev_rst;
  logic halted;
  logic vdd_ok = 1'b0;
  logic go = 1'b0;
  logic [7:0] hold = 8'h01;
  int bad_count = 0;
  int checked = 0;
  logic [31:0] rnd = 32'hb830;
  int m_to;
  int m_pd;
  int m_page;
  int m_alu;
  bit alu_known = 1'b0;

  initial forever #2 clk = ~clk;

  rcs_reset_control #(.STARTUP_CYCLES(SC)) dut_u (.clk(clk), .resetn(resetn),
    .ext_clear_pin_n(pin_n), .wdt_timeout(wdt), .sleep_cmd(sleep), .reg_addr(addr),
    .reg_we(we), .reg_wdata(wdata), .reg_rdata(rdata), .device_reset(dev_rst),
    .halted(halted));
  rcs_supervisor sup_u (.clk(clk), .vdd_ok(vdd_ok), .go(go), .hold(hold),
    .ext_clear_pin_n(pin_n));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Alu bits are unknown until first written, so masked till then
  task automatic rd_status;
    logic [7:0] mask;
    mask = alu_known ? 8'hff : 8'hf8;
    addr = 5'h03;
    tick();
    chk("status", {m_page[2:0], m_to[0], m_pd[0], m_alu[2:0]} & mask, rdata & mask);
    addr = (rnd[4:0] == 5'h03) ? 5'h04 : rnd[4:0];
    tick();
    chk("unmapped", 8'h00, rdata);
    addr = 5'h03;
  endtask : rd_status

  // Flag bits are read-only, so the write leaves them alone
  task automatic wr(input logic [7:0] d);
    we = 1'b1;
    wdata = d;
    tick();
    we = 1'b0;
    m_page = d[7:5];
    m_alu = d[2:0];
    alu_known = 1'b1;
  endtask : wr

  task automatic wait_run(input int e);
    int n;
    n = 0;
    while (dev_rst !== 1'b0 && n < 300)
    begin
      n++;
      tick();
    end
    chk("reset length", 8'(e), 8'(n));
  endtask : wait_run

  task automatic start_clear;
    int n;
    n = 0;
    rnd = lfsr(rnd);
    hold = 8'(1 + rnd[1:0]);
    go = 1'b1;
    tick();
    go = 1'b0;
    tick();
    while (pin_n !== 1'b1 && n < 300)
    begin
      n++;
      tick();
    end
    m_page = 0;
  endtask : start_clear

  // Kind bit 0 picks watchdog over clear pin, bit 1 enters halt first
  task automatic do_reset(input int k);
    rnd = lfsr(rnd);
    wr(rnd[15:8]);
    if (k >= 2)
    begin
      sleep = 1'b1;
      tick();
      sleep = 1'b0;
      chk("halted", 8'h01, 8'(halted));
    end
    if (k % 2 == 1)
    begin
      wdt = 1'b1;
      tick();
      wdt = 1'b0;
      wait_run(SC);
      m_page = 0;
    end
    else
    begin
      // Counting starts on the edge that first sees the pin high
      start_clear();
      wait_run(SC);
    end
    chk("halted", 8'h00, 8'(halted));
    if (k != 0)
    begin
      m_to = (k == 2);
      m_pd = (k == 1);
    end
    rd_status();
    $display("test reset kind %0d done", k);
  endtask : do_reset

  task automatic results;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    tick();
    tick();
    chk("reset at power-on", 8'h01, 8'(dev_rst));
    chk("read at power-on", 8'h00, rdata);
    resetn = 1'b1;
    m_to = 1;
    m_pd = 1;
    m_page = 0;
    repeat (SC + 4) tick();
    chk("held while pin low", 8'h01, 8'(dev_rst));
    vdd_ok = 1'b1;
    while (pin_n !== 1'b1)
      tick();
    wait_run(SC);
    rd_status();
    $display("test power-on done");
    repeat (3)
    begin
      rnd = lfsr(rnd);
      wr(rnd[7:0]);
      rd_status();
    end
    $display("test writes done");
    for (int k = 0; k < 8; k++)
      do_reset(k % 4);
    start_clear();
    repeat (6) tick();
    wdt = 1'b1;
    tick();
    wdt = 1'b0;
    start_clear();
    wait_run(SC);
    rd_status();
    $display("test restart done");
    results();
  end

  initial
  begin
    #(4 * 3000);
    bad_count++;
    results();
  end
endmodule : rcs_reset_control_tb
